// ==== icd_checker.sv ====
// pin-level assertions for the two-wire slave port
// assumes it is bound to icd_slave_port and sda_in is the resolved wire
module icd_checker
(
  input wire logic       sys_clk_in,
  input wire logic       arst_n_in,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_out,
  input wire logic [7:0] current_output_zero_out,
  input wire logic [7:0] current_output_one_out,
  input wire logic [7:0] current_output_two_out,
  input wire logic [7:0] current_output_three_out,
  input wire logic       bus_busy_out
);
  timeunit 1ns;
  timeprecision 10ps;
  wire [31:0] regs = {current_output_zero_out, current_output_one_out,
                      current_output_two_out, current_output_three_out};
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);
  // ----------------------------
  // properties
  // ----------------------------
  property p_drv_low; sda_oe_out |-> !sda_out; endproperty
  a_drv_low: assert property (p_drv_low) else $error("sda driven high");
  property p_start; scl_in && $fell(sda_in) |-> ##[1:6] bus_busy_out; endproperty
  a_start: assert property (p_start) else $error("start not seen");
  property p_stop; scl_in && $rose(sda_in) |-> ##[1:6] !bus_busy_out; endproperty
  a_stop: assert property (p_stop) else $error("stop not seen");
  // sync delay is short against the low phase, so drive edges fall inside it
  property p_oe_low; $changed(sda_oe_out) |-> !scl_in; endproperty
  a_oe_low: assert property (p_oe_low) else $error("sda moved with scl high");
  property p_idle; !bus_busy_out |-> !sda_oe_out; endproperty
  a_idle: assert property (p_idle) else $error("sda driven while idle");
  property p_keep; !bus_busy_out && !$past(bus_busy_out) |-> $stable(regs); endproperty
  a_keep: assert property (p_keep) else $error("register moved while idle");
  property p_hold; $rose(sda_oe_out) |-> sda_oe_out[*6]; endproperty
  a_hold: assert property (p_hold) else $error("driven bit too short");
  property p_rst; $rose(arst_n_in) |-> regs == 32'h0000_0000 && !bus_busy_out; endproperty
  a_rst: assert property (p_rst) else $error("bad reset value");
endmodule

bind icd_slave_port icd_checker u_chk
(
  .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_out(sda_oe_out), .bus_busy_out(bus_busy_out),
  .current_output_zero_out(current_output_zero_out), .current_output_one_out(current_output_one_out),
  .current_output_two_out(current_output_two_out), .current_output_three_out(current_output_three_out)
);

// ==== icd_master_model.sv ====
// behavioural two-wire bus master, one bit every 125 ns
// assumes the bench resolves sda as a pulled-up wire-and
module icd_master_model
(
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  timeunit 1ns;
  timeprecision 10ps;
  // ----------------------------
  // bus phases
  // ----------------------------
  // scl stands high between frames
  initial
  begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic start;
    sda_low_out = 1'b0;
    #31.25 scl_out = 1'b1;
    #31.25 sda_low_out = 1'b1;
    #31.25 scl_out = 1'b0;
    #31.25;
  endtask
  task automatic stop;
    sda_low_out = 1'b1;
    #31.25 scl_out = 1'b1;
    #31.25 sda_low_out = 1'b0;
    #62.5;
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_low_out = !b;
    #31.25 scl_out = 1'b1;
    #31.25 r = sda_in;
    #31.25 scl_out = 1'b0;
    #31.25;
  endtask
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(a, k);
  endtask
endmodule

// ==== icd_regs.vh ====
// constants for the two-wire slave port of the four-channel current dac
// assumes a 100 mhz system clock and a bus master that owns scl
`ifndef ICD_REGS_VH
`define ICD_REGS_VH

// ------------------------------------------------------------
// addressing
// ------------------------------------------------------------
`define ICD_SLAVE_ADDR_BASE  7'h48
`define ICD_MEM_INDEX_CURRENT_OUTPUT_ZERO   8'hF8
`define ICD_MEM_INDEX_CURRENT_OUTPUT_THREE   8'hFB
`define ICD_DIR_WRITE        1'b0
`define ICD_DIR_READ         1'b1

// ------------------------------------------------------------
// output control register layout
// ------------------------------------------------------------
`define ICD_CTRL_SIGN_BIT    7
`define ICD_CTRL_MAG_MSB     6
`define ICD_CTRL_RESET       8'h00
`define ICD_INDEX_RESET      8'h00

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define ICD_BITS_PER_BYTE    4'h8
`define ICD_ACK_SLOT         4'h8

`endif

// ==== icd_slave_port.v ====
// two-wire slave port and output control registers of a four-channel current dac
// assumes scl comes from the bus master and is sampled by sys_clk_in; sda is open-drain
//
// Overview of operation
// - falling sda with scl high starts transfer
// - rising sda with scl high stops transfer
// - repeated start behaves like ordinary start
// - incoming bits sampled at scl rise
// - outgoing bits change on scl fall
// - ninth bit is acknowledge from receiver
// - zero acknowledges, one refuses or ends
// - written bytes arrive msb first, device acks
// - read bytes go msb first until nack
// - first byte holds address and direction
// - direction zero writes, one reads
// - own address chosen by two straps
// - straps give address bytes 90h to 97h
// - mismatch gets no ack, wait for start
// - second write byte is memory index
// - idle between stop and start
// - indices f8h to fbh select outputs
// - bit seven selects sink or source
`include "icd_regs.vh"

module icd_slave_port
(
  input  wire       sys_clk_in,
  input  wire       arst_n_in,
  input  wire       scl_in,
  input  wire       sda_in,
  input  wire       addr_strap_low_in,
  input  wire       addr_strap_high_in,
  output reg        sda_out,
  output reg        sda_oe_out,
  output reg  [7:0] current_output_zero_out,
  output reg  [7:0] current_output_one_out,
  output reg  [7:0] current_output_two_out,
  output reg  [7:0] current_output_three_out,
  output reg        bus_busy_out
);

  // ------------------------------------------------------------
  // reset release and pin synchronisation
  // ------------------------------------------------------------
  reg        rst_meta;
  reg        rst_n;
  wire [3:0] pins_sync;
  reg        scl_d;
  reg        sda_d;

  // reset is taken at once but let go on a clock edge, so no flop sees a recovery race
  always @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  icd_sync #(.WIDTH(4)) u_sync
  (
    .clk_in   (sys_clk_in),
    .rst_n_in (rst_n),
    .async_in ({addr_strap_high_in, addr_strap_low_in, sda_in, scl_in}),
    .sync_out (pins_sync)
  );

  wire scl       = pins_sync[0];
  wire sda       = pins_sync[1];
  wire strap_lo  = pins_sync[2];
  wire strap_hi  = pins_sync[3];

  always @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_d <= scl;
      sda_d <= sda;
    end
  end

  // both lines share one synchroniser, so the order of their edges survives
  wire scl_rise   = scl & ~scl_d;
  wire scl_fall   = ~scl & scl_d;
  wire start_cond = scl & scl_d & sda_d & ~sda;
  wire stop_cond  = scl & scl_d & ~sda_d & sda;

  // own address: straps pick the low two address bits
  wire [6:0] own_addr = `ICD_SLAVE_ADDR_BASE | {5'h00, strap_hi, strap_lo};

  // ------------------------------------------------------------
  // state machine
  // ------------------------------------------------------------
  localparam [5:0] ST_IDLE  = 6'b00_0001;
  localparam [5:0] ST_ADDR  = 6'b00_0010;
  localparam [5:0] ST_INDEX = 6'b00_0100;
  localparam [5:0] ST_DATA  = 6'b00_1000;
  localparam [5:0] ST_READ  = 6'b01_0000;
  localparam [5:0] ST_WAIT  = 6'b10_0000;

  reg [5:0] state;
  reg [5:0] next_state;
  reg [3:0] bit_cnt;
  reg [7:0] shift;
  reg [7:0] tx_shift;
  reg [7:0] mem_index;
  reg       ack_slot;
  reg       acking;
  reg       read_ok;
  reg       rd_start;
  reg [7:0] ctrl [0:3];

  wire [7:0] rx_byte = {shift[6:0], sda};
  wire [7:0] idx_base = `ICD_MEM_INDEX_CURRENT_OUTPUT_ZERO;
  // only f8h..fbh map onto the array; other indices read zero and drop writes
  wire       idx_ok  = (mem_index[7:2] == idx_base[7:2]);
  wire [7:0] rd_val  = idx_ok ? ctrl[mem_index[1:0]] : 8'h00;
  // eighth data rise; the rise after it is the acknowledge slot
  wire       byte_done = scl_rise && (bit_cnt == `ICD_BITS_PER_BYTE - 4'h1) && !ack_slot;

  // next state only matters on the last rise of a byte
  always @*
  begin
    next_state = state;
    if (byte_done)
    begin
      case (state)
        ST_ADDR:
          next_state = (rx_byte[7:1] == own_addr) ?
                       (rx_byte[0] == `ICD_DIR_READ ? ST_READ : ST_INDEX)
                       : ST_WAIT;
        ST_INDEX: next_state = ST_DATA;
        default:  next_state = state;
      endcase
    end
  end

  integer i;

  // start and stop win over bit handling, so a cut byte never commits
  always @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state        <= ST_IDLE;
      bit_cnt      <= 4'h0;
      shift        <= 8'h00;
      tx_shift     <= 8'h00;
      mem_index    <= `ICD_INDEX_RESET;
      ack_slot     <= 1'b0;
      acking       <= 1'b0;
      read_ok      <= 1'b0;
      sda_out      <= 1'b0;
      sda_oe_out   <= 1'b0;
      bus_busy_out <= 1'b0;
      for (i = 0; i < 4; i = i + 1)
        ctrl[i] <= `ICD_CTRL_RESET;
    end
    else if (start_cond)
    begin
      state        <= ST_ADDR;
      bit_cnt      <= 4'h0;
      ack_slot     <= 1'b0;
      acking       <= 1'b0;
      sda_oe_out   <= 1'b0;
      bus_busy_out <= 1'b1;
    end
    else if (stop_cond)
    begin
      state        <= ST_IDLE;
      bit_cnt      <= 4'h0;
      ack_slot     <= 1'b0;
      acking       <= 1'b0;
      sda_oe_out   <= 1'b0;
      bus_busy_out <= 1'b0;
    end
    else if (state != ST_IDLE && state != ST_WAIT)
    begin
      if (scl_rise)
      begin
        if (ack_slot)
        begin
          ack_slot <= 1'b0;
          bit_cnt  <= 4'h0;
          // master nack ends the read and frees sda
          if (state == ST_READ)
            read_ok <= ~sda;
        end
        else
        begin
          shift   <= rx_byte;
          bit_cnt <= bit_cnt + 4'h1;
          if (byte_done)
          begin
            ack_slot <= 1'b1;
            state    <= next_state;
            if (state == ST_INDEX)
              mem_index <= rx_byte;
            if (state == ST_DATA && idx_ok)
              ctrl[mem_index[1:0]] <= rx_byte;
          end
        end
      end
      else if (scl_fall)
      begin
        if (ack_slot && state != ST_READ && state != ST_WAIT)
        begin
          // device is receiver: drive zero during the ninth bit
          acking     <= 1'b1;
          sda_out    <= 1'b0;
          sda_oe_out <= 1'b1;
        end
        else if (ack_slot && state == ST_READ && rd_start)
        begin
          // address ack for a read, then first data bit follows
          acking     <= 1'b1;
          sda_out    <= 1'b0;
          sda_oe_out <= 1'b1;
          read_ok    <= 1'b1;
        end
        else if (state == ST_READ && !ack_slot && read_ok)
        begin
          if (bit_cnt == 4'h0)
          begin
            sda_out    <= rd_val[7];
            sda_oe_out <= ~rd_val[7];
            tx_shift   <= {rd_val[6:0], 1'b0};
          end
          else
          begin
            sda_out    <= tx_shift[7];
            sda_oe_out <= ~tx_shift[7];
            tx_shift   <= {tx_shift[6:0], 1'b0};
          end
          acking <= 1'b0;
        end
        else
        begin
          acking     <= 1'b0;
          sda_out    <= 1'b0;
          sda_oe_out <= 1'b0;
        end
      end
    end
    // refused address: stay off the bus until the next start
    else if (state == ST_WAIT)
      sda_oe_out <= 1'b0;
  end

  // read ack slot is the one right after the address byte
  always @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      rd_start <= 1'b0;
    else if (start_cond || stop_cond)
      rd_start <= 1'b0;
    else if (byte_done && state == ST_ADDR)
      rd_start <= (rx_byte[7:1] == own_addr) && rx_byte[0];
    else if (scl_rise && ack_slot)
      rd_start <= 1'b0;
  end

  // ------------------------------------------------------------
  // register outputs
  // ------------------------------------------------------------
  // ports trail the array by one clock so that each comes straight from a flop
  always @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      current_output_zero_out  <= `ICD_CTRL_RESET;
      current_output_one_out   <= `ICD_CTRL_RESET;
      current_output_two_out   <= `ICD_CTRL_RESET;
      current_output_three_out <= `ICD_CTRL_RESET;
    end
    else
    begin
      current_output_zero_out  <= ctrl[0];
      current_output_one_out   <= ctrl[1];
      current_output_two_out   <= ctrl[2];
      current_output_three_out <= ctrl[3];
    end
  end

endmodule

// ==== icd_slave_port_test.sv ====
// self-checking bench for the slave port: write, read back, refusals, aborts
// assumes the master model and checker files are compiled first
module icd_slave_port_test;
  timeunit 1ns;
  timeprecision 10ps;
  logic       sys_clk_in, arst_n_in, strap_lo, strap_hi, k;
  wire        scl, sda_low, sda_oe;
  wire  [7:0] o0, o1, o2, o3;
  wire        sda = !(sda_oe | sda_low);
  int         miscompares, checks, cyc;
  logic [7:0] exp_reg[4], q, d;
  icd_slave_port u_dut
  (
    .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .scl_in(scl), .sda_in(sda),
    .addr_strap_low_in(strap_lo), .addr_strap_high_in(strap_hi), .sda_out(), .sda_oe_out(sda_oe),
    .current_output_zero_out(o0), .current_output_one_out(o1), .current_output_two_out(o2),
    .current_output_three_out(o3), .bus_busy_out()
  );
  icd_master_model u_mst (.sda_in(sda), .scl_out(scl), .sda_low_out(sda_low));
  // ----------------------------
  // helpers
  // ----------------------------
  always #5 sys_clk_in = !sys_clk_in;
  // limit is several times the expected run
  always @(posedge sys_clk_in)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      miscompares++;
      conclude();
    end
  end
  task automatic conclude;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string n, input logic [7:0] s, e);
    checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  function automatic logic [7:0] dev(input logic rd);
    return 8'h90 | {5'h00, strap_hi, strap_lo, rd};
  endfunction
  task automatic outs;
    check("current_output_zero", o0, exp_reg[0]);
    check("out1", o1, exp_reg[1]);
    check("out2", o2, exp_reg[2]);
    check("current_output_three", o3, exp_reg[3]);
  endtask
  // a refused address leaves every later byte unanswered too
  task automatic wr(input logic [7:0] a, i, v, ak);
    u_mst.start();
    u_mst.xfer(a, 1'b1, q, k);
    check("addr ack", 8'(k), ak);
    u_mst.xfer(i, 1'b1, q, k);
    check("index ack", 8'(k), ak);
    u_mst.xfer(v, 1'b1, q, k);
    check("data ack", 8'(k), ak);
    u_mst.stop();
  endtask
  task automatic rd(input logic [7:0] i, e);
    u_mst.start();
    u_mst.xfer(dev(1'b0), 1'b1, q, k);
    u_mst.xfer(i, 1'b1, q, k);
    u_mst.start();
    u_mst.xfer(dev(1'b1), 1'b1, q, k);
    check("read ack", 8'(k), 8'h00);
    u_mst.xfer(8'hff, 1'b1, q, k);
    check("read data", q, e);
    u_mst.stop();
  endtask
  // ----------------------------
  // sequence
  // ----------------------------
  initial
  begin
    {sys_clk_in, arst_n_in, strap_lo, strap_hi} = 4'h0;
    exp_reg = '{default: 8'h00};
    void'($urandom(32'hcb08_5c61));
    repeat (4) @(posedge sys_clk_in);
    #1 arst_n_in = 1'b1;
    repeat (8) @(posedge sys_clk_in);
    outs();
    $display("test reset done");
    for (int s = 0; s < 4; s++)
    begin
      @(posedge sys_clk_in);
      #1 {strap_hi, strap_lo} = s[1:0];
      repeat (4) @(posedge sys_clk_in);
      d = 8'($urandom);
      wr(dev(1'b0), 8'hf8 + 8'(s), d, 8'h00);
      exp_reg[s] = d;
      outs();
      rd(8'hf8 + 8'(s), d);
      wr(dev(1'b0) ^ 8'h02, 8'hf8 + 8'(s), ~d, 8'h01);
      outs();
      $display("test strap %0d done", s);
    end
    wr(dev(1'b0), 8'hf7, 8'h55, 8'h00);
    rd(8'hf7, 8'h00);
    outs();
    $display("test unmapped index done");
    u_mst.start();
    u_mst.xfer(dev(1'b0), 1'b1, q, k);
    u_mst.xfer(8'hf8, 1'b1, q, k);
    repeat (4) u_mst.bit_io(1'b0, k);
    u_mst.stop();
    outs();
    rd(8'hf8, exp_reg[0]);
    $display("test aborted byte done");
    u_mst.start();
    u_mst.xfer(dev(1'b1), 1'b1, q, k);
    check("plain read ack", 8'(k), 8'h00);
    u_mst.xfer(8'hff, 1'b0, q, k);
    check("acked read byte", q, exp_reg[0]);
    u_mst.xfer(8'hff, 1'b1, q, k);
    check("last read byte", q, exp_reg[0]);
    u_mst.stop();
    $display("test acked read done");
    @(posedge sys_clk_in);
    #1 arst_n_in = 1'b0;
    repeat (4) @(posedge sys_clk_in);
    #1 arst_n_in = 1'b1;
    exp_reg = '{default: 8'h00};
    repeat (8) @(posedge sys_clk_in);
    outs();
    rd(8'hf9, 8'h00);
    $display("test mid-run reset done");
    conclude();
  end
endmodule

// ==== icd_sync.v ====
// two-flop synchroniser for the bus pins
// assumes inputs are asynchronous to sys_clk_in
module icd_sync
#(
  parameter WIDTH = 2
)
(
  input  wire             clk_in,
  input  wire             rst_n_in,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage_a;
  reg [WIDTH-1:0] stage_b;

  // first stage feeds only the second
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      stage_a <= {WIDTH{1'b1}};
      stage_b <= {WIDTH{1'b1}};
    end
    else
    begin
      stage_a <= async_in;
      stage_b <= stage_a;
    end
  end

  assign sync_out = stage_b;

endmodule
